/* File: rtcc_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcc_chk (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic alarm_enable_i,
  input wire logic watchdog_function_i,
  input wire logic interrupt_line_one_n_o,
  input wire logic irq_o,
  input wire logic square_output_o,
  input wire logic freq_check_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // Read data only in the slot after a read, zero elsewhere
  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data seen outside its slot");
  chk_flag_release: assert property (
    (rd_i && addr_i == 8'h02) |=> interrupt_line_one_n_o)
    else $error("line one still low after flag read");
  chk_flag_bits: assert property (
    (rd_i && addr_i == 8'h02) |=> rdata_o[7:2] == 6'h00)
    else $error("flag register upper bits set");
  chk_cal_width: assert property (
    (rd_i && addr_i == 8'h03) |=> rdata_o[7] == 1'b0)
    else $error("calibration bit 7 set");
  // Frequency check output must be quiet while another function owns the pin
  chk_alarm_blocks: assert property (
    (alarm_enable_i && $past(alarm_enable_i)) |-> !freq_check_o)
    else $error("freq check active with alarm on");
  chk_wdg_blocks: assert property (
    (watchdog_function_i && $past(watchdog_function_i)) |-> !freq_check_o)
    else $error("freq check active with watchdog on");
  chk_irq_fall: assert property ($fell(irq_o) |-> $past(wr_i))
    else $error("irq dropped without a write");
  // Half period is at least a whole base tick, so no rising edge may follow within 8 clocks
  chk_square_hold: assert property (
    $changed(square_output_o) |=> (!square_output_o || $stable(square_output_o)) [*8])
    else $error("square output toggled too fast");
  chk_unmapped_zero: assert property (
    (rd_i && addr_i > 8'h0B) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind rtcc_top rtcc_chk i_rtcc_chk (.clk_i, .nrst_i, .addr_i, .wr_i, .rd_i, .rdata_o,
  .alarm_enable_i, .watchdog_function_i, .interrupt_line_one_n_o, .irq_o,
  .square_output_o, .freq_check_o);
`default_nettype wire

/* File: rtcc_host_mdl.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcc_host_mdl (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  // Idle bus at time zero
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // One-cycle write; a zero start value is never sent since it means a roll each tick
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
    if (a == 8'h00 && v == 8'h00) return;
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= v;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~v;
  endtask

  // Data is taken in the single cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    v = rdata_i;
  endtask
endmodule
`default_nettype wire

/* File: rtcc_pkg.sv */
package rtcc_pkg;
  // Clock rate and derived tick rates
  localparam int CLK_HZ = 125_000_000;
  localparam int BASE_HZ = 4096;
  localparam int BASE_DIV = CLK_HZ / BASE_HZ;
  localparam int SUB_TICKS = 4096;
  localparam int SEC_PER_MIN = 60;

  // Register offsets (byte addresses on the plain port)
  localparam logic [7:0] ADDR_TIMER_VAL = 8'h00;
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h01;
  localparam logic [7:0] ADDR_FLAGS = 8'h02;
  localparam logic [7:0] ADDR_CAL = 8'h03;
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h04;
  localparam logic [7:0] ADDR_TIMER_CNT = 8'h05;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h06;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h07;
  localparam logic [7:0] ADDR_TIME_B0 = 8'h08;
  localparam logic [7:0] ADDR_TIME_B1 = 8'h09;
  localparam logic [7:0] ADDR_TIME_B2 = 8'h0A;
  localparam logic [7:0] ADDR_TIME_B3 = 8'h0B;

  // Field positions
  localparam int TC_RUN = 0;
  localparam int TC_STYLE = 1;
  localparam int TC_IRQ_EN = 2;
  localparam int TC_FSEL_LO = 3;
  localparam int FL_ROLL = 0;
  localparam int FL_HALT = 1;
  localparam int CAL_SIGN = 5;
  localparam int CAL_FT = 6;
  localparam int CC_HALT = 0;
  localparam int CC_SQW_EN = 1;
  localparam int CC_SQW_LO = 2;
  localparam int IRQ_ROLL = 0;
  localparam int IRQ_PDOWN = 1;

  // Reset values
  localparam logic [7:0] RST_TIMER_VAL = 8'h01;
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;
  localparam logic RST_HALT = 1'b1;

  // Tick-source selections for the timer
  typedef enum logic [1:0] {
    RTCC_T_BASE,
    RTCC_T_64HZ,
    RTCC_T_1HZ,
    RTCC_T_1MIN
  } rtcc_tsel_t;
endpackage

/* File: rtcc_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcc_tick_gen #(
  parameter logic [15:0] BASE_DIV = 16'(rtcc_pkg::BASE_DIV)
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  rtcc_tick_if.gen tk
);
  typedef struct packed {
    logic [15:0] div_cnt;
    logic [11:0] sub;
    logic [5:0] sec;
    logic base;
    logic t64;
    logic t1;
    logic tmin;
  } rtcc_tick_st_t;

  rtcc_tick_st_t st_reg;
  rtcc_tick_st_t st_next;
  logic [15:0] period;

  // Calibration stretches or shortens the last base tick of each second
  always_comb begin
    if (tk.cal_neg) begin
      period = BASE_DIV - {11'h000, tk.cal_mag};
    end else begin
      period = BASE_DIV + {11'h000, tk.cal_mag};
    end
    if (st_reg.sub != 12'(rtcc_pkg::SUB_TICKS - 1)) begin
      period = BASE_DIV;
    end
  end

  // Divider chain: base ticks, 64 Hz, 1 Hz, one per minute
  always_comb begin
    st_next = st_reg;
    st_next.base = 1'b0;
    st_next.t64 = 1'b0;
    st_next.t1 = 1'b0;
    st_next.tmin = 1'b0;
    if (st_reg.div_cnt == period - 16'h0001) begin
      st_next.div_cnt = 16'h0000;
      st_next.base = 1'b1;
      st_next.sub = st_reg.sub + 12'h001;
      st_next.t64 = (st_reg.sub[5:0] == 6'h3F);
      if (st_reg.sub == 12'(rtcc_pkg::SUB_TICKS - 1)) begin
        st_next.t1 = 1'b1;
        if (st_reg.sec == 6'(rtcc_pkg::SEC_PER_MIN - 1)) begin
          st_next.sec = 6'h00;
          st_next.tmin = 1'b1;
        end else begin
          st_next.sec = st_reg.sec + 6'h01;
        end
      end
    end else begin
      st_next.div_cnt = st_reg.div_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tk.tick_base = st_reg.base;
  assign tk.tick_64 = st_reg.t64;
  assign tk.tick_1 = st_reg.t1;
  assign tk.tick_min = st_reg.tmin;
  assign tk.phase = st_reg.sub;
endmodule
`default_nettype wire

/* File: rtcc_tick_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Calibration in, tick enables and phase out
interface rtcc_tick_if;
  logic [4:0] cal_mag;
  logic cal_neg;
  logic tick_base;
  logic tick_64;
  logic tick_1;
  logic tick_min;
  logic [11:0] phase;
  modport gen (input cal_mag, cal_neg, output tick_base, tick_64, tick_1, tick_min, phase);
  modport use_side (output cal_mag, cal_neg, input tick_base, tick_64, tick_1, tick_min, phase);
endinterface
`default_nettype wire

/* File: rtcc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcc_top #(
  parameter logic [15:0] BASE_DIV = 16'(rtcc_pkg::BASE_DIV)
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic power_down_i,
  input wire logic alarm_enable_i,
  input wire logic watchdog_function_i,
  output logic interrupt_line_one_n_o,
  output logic irq_o,
  output logic square_output_o,
  output logic freq_check_o
);
  typedef struct packed {
    logic pd_s1;
    logic pd_s2;
    logic pd_prev;
    logic [7:0] timer_start;
    logic [7:0] timer_count;
    logic timer_run_enable;
    logic timer_output_style_select;
    logic timer_irq_enable;
    logic [1:0] fsel;
    logic rollover_flag;
    logic roll_pulse;
    logic [4:0] cal_mag;
    logic cal_neg;
    logic freq_check_bit;
    logic halt_update_bit;
    logic sqw_en;
    logic [1:0] sqw_sel;
    logic [31:0] time_run;
    logic [31:0] time_view;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [7:0] rdata;
    logic sqw_out;
    logic ft_out;
  } rtcc_state_t;

  rtcc_state_t st_reg;
  rtcc_state_t st_next;
  logic timer_tick;
  logic rollover;
  logic pd_rise;
  logic flag_read;
  logic wr_tval;
  logic [7:0] rd_mux;
  logic sqw_phase;

  rtcc_tick_if tk ();

  rtcc_tick_gen #(
    .BASE_DIV(BASE_DIV)
  ) u_tick (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .tk(tk)
  );

  assign tk.cal_mag = st_reg.cal_mag;
  assign tk.cal_neg = st_reg.cal_neg;

  // Select the timer tick source from the divider chain
  always_comb begin
    unique case (rtcc_pkg::rtcc_tsel_t'(st_reg.fsel))
      rtcc_pkg::RTCC_T_BASE: timer_tick = tk.tick_base;
      rtcc_pkg::RTCC_T_64HZ: timer_tick = tk.tick_64;
      rtcc_pkg::RTCC_T_1HZ: timer_tick = tk.tick_1;
      rtcc_pkg::RTCC_T_1MIN: timer_tick = tk.tick_min;
    endcase
  end

  // Square-wave phase per frequency selection
  always_comb begin
    unique case (st_reg.sqw_sel)
      2'h0: sqw_phase = tk.phase[0];
      2'h1: sqw_phase = tk.phase[3];
      2'h2: sqw_phase = tk.phase[5];
      2'h3: sqw_phase = tk.phase[11];
    endcase
  end

  // Count of 0 or 1 both roll over, so a stray zero cannot lock the timer up
  assign rollover = timer_tick && st_reg.timer_run_enable && (st_reg.timer_count <= 8'h01);
  assign pd_rise = st_reg.pd_s2 && !st_reg.pd_prev;
  assign flag_read = rd_i && (addr_i == rtcc_pkg::ADDR_FLAGS);
  assign wr_tval = wr_i && (addr_i == rtcc_pkg::ADDR_TIMER_VAL);

  // Read multiplexer; unmapped addresses read as zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (addr_i)
      rtcc_pkg::ADDR_TIMER_VAL: rd_mux = st_reg.timer_start;
      rtcc_pkg::ADDR_TIMER_CTRL: begin
        rd_mux[rtcc_pkg::TC_RUN] = st_reg.timer_run_enable;
        rd_mux[rtcc_pkg::TC_STYLE] = st_reg.timer_output_style_select;
        rd_mux[rtcc_pkg::TC_IRQ_EN] = st_reg.timer_irq_enable;
        rd_mux[rtcc_pkg::TC_FSEL_LO +: 2] = st_reg.fsel;
      end
      rtcc_pkg::ADDR_FLAGS: begin
        rd_mux[rtcc_pkg::FL_ROLL] = st_reg.rollover_flag;
        rd_mux[rtcc_pkg::FL_HALT] = st_reg.halt_update_bit;
      end
      rtcc_pkg::ADDR_CAL: begin
        rd_mux[4:0] = st_reg.cal_mag;
        rd_mux[rtcc_pkg::CAL_SIGN] = st_reg.cal_neg;
        rd_mux[rtcc_pkg::CAL_FT] = st_reg.freq_check_bit;
      end
      rtcc_pkg::ADDR_CLK_CTRL: begin
        rd_mux[rtcc_pkg::CC_HALT] = st_reg.halt_update_bit;
        rd_mux[rtcc_pkg::CC_SQW_EN] = st_reg.sqw_en;
        rd_mux[rtcc_pkg::CC_SQW_LO +: 2] = st_reg.sqw_sel;
      end
      rtcc_pkg::ADDR_TIMER_CNT: rd_mux = st_reg.timer_count;
      rtcc_pkg::ADDR_IRQ_STAT: rd_mux[1:0] = st_reg.irq_status;
      rtcc_pkg::ADDR_IRQ_MASK: rd_mux[1:0] = st_reg.irq_mask;
      rtcc_pkg::ADDR_TIME_B0: rd_mux = st_reg.time_view[7:0];
      rtcc_pkg::ADDR_TIME_B1: rd_mux = st_reg.time_view[15:8];
      rtcc_pkg::ADDR_TIME_B2: rd_mux = st_reg.time_view[23:16];
      rtcc_pkg::ADDR_TIME_B3: rd_mux = st_reg.time_view[31:24];
      default: rd_mux = 8'h00;
    endcase
  end

  // Next-state logic for every register of the block
  always_comb begin
    st_next = st_reg;
    // Power-down pin resynchronised before use
    st_next.pd_s1 = power_down_i;
    st_next.pd_s2 = st_reg.pd_s1;
    st_next.pd_prev = st_reg.pd_s2;
    st_next.rdata = rd_i ? rd_mux : 8'h00;

    // Host writes to configuration registers
    if (wr_i) begin
      unique case (addr_i)
        rtcc_pkg::ADDR_TIMER_VAL: st_next.timer_start = wdata_i;
        rtcc_pkg::ADDR_TIMER_CTRL: begin
          st_next.timer_run_enable = wdata_i[rtcc_pkg::TC_RUN];
          st_next.timer_output_style_select = wdata_i[rtcc_pkg::TC_STYLE];
          st_next.timer_irq_enable = wdata_i[rtcc_pkg::TC_IRQ_EN];
          st_next.fsel = wdata_i[rtcc_pkg::TC_FSEL_LO +: 2];
        end
        rtcc_pkg::ADDR_CAL: begin
          st_next.cal_mag = wdata_i[4:0];
          st_next.cal_neg = wdata_i[rtcc_pkg::CAL_SIGN];
          st_next.freq_check_bit = wdata_i[rtcc_pkg::CAL_FT];
        end
        rtcc_pkg::ADDR_CLK_CTRL: begin
          st_next.halt_update_bit = wdata_i[rtcc_pkg::CC_HALT];
          st_next.sqw_en = wdata_i[rtcc_pkg::CC_SQW_EN];
          st_next.sqw_sel = wdata_i[rtcc_pkg::CC_SQW_LO +: 2];
        end
        rtcc_pkg::ADDR_IRQ_STAT: st_next.irq_status = st_reg.irq_status & ~wdata_i[1:0];
        rtcc_pkg::ADDR_IRQ_MASK: st_next.irq_mask = wdata_i[1:0];
        default: st_next.rdata = st_next.rdata;
      endcase
    end

    // Countdown with automatic reload; a new start value loads at once
    if (wr_tval) begin
      st_next.timer_count = wdata_i;
    end else if (rollover) begin
      st_next.timer_count = st_reg.timer_start;
    end else if (timer_tick && st_reg.timer_run_enable) begin
      st_next.timer_count = st_reg.timer_count - 8'h01;
    end

    // Flag read clears, but a rollover in the same cycle wins
    if (flag_read) begin
      st_next.rollover_flag = 1'b0;
      st_next.roll_pulse = 1'b0;
    end
    if (tk.tick_base) begin
      st_next.roll_pulse = 1'b0;
    end
    if (rollover) begin
      st_next.rollover_flag = 1'b1;
      st_next.roll_pulse = 1'b1;
    end

    // Power-down sets halt; set outranks a host clear in the same cycle
    if (pd_rise) begin
      st_next.halt_update_bit = 1'b1;
    end

    // Internal time keeps running; the visible copy follows only while not halted
    if (tk.tick_1) begin
      st_next.time_run = st_reg.time_run + 32'h0000_0001;
    end
    if (!st_reg.halt_update_bit) begin
      st_next.time_view = st_reg.time_run;
    end

    // Sticky event bits, set winning over a write-one clear
    if (rollover) begin
      st_next.irq_status[rtcc_pkg::IRQ_ROLL] = 1'b1;
    end
    if (pd_rise) begin
      st_next.irq_status[rtcc_pkg::IRQ_PDOWN] = 1'b1;
    end

    // Pin outputs registered to keep them glitch free
    st_next.sqw_out = st_reg.sqw_en && sqw_phase;
    st_next.ft_out = st_reg.freq_check_bit && tk.phase[2]
                     && !(alarm_enable_i || watchdog_function_i || st_reg.sqw_en);
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
      st_reg.timer_start <= rtcc_pkg::RST_TIMER_VAL;
      st_reg.timer_count <= rtcc_pkg::RST_TIMER_VAL;
      st_reg.halt_update_bit <= rtcc_pkg::RST_HALT;
      st_reg.irq_mask <= rtcc_pkg::RST_IRQ_MASK;
    end else begin
      st_reg <= st_next;
    end
  end

  // Level style follows the flag, pulse style lasts to the next base tick
  assign interrupt_line_one_n_o = !(st_reg.timer_irq_enable
      && (st_reg.timer_output_style_select ? st_reg.roll_pulse
                                           : st_reg.rollover_flag));
  assign irq_o = |(st_reg.irq_status & st_reg.irq_mask);
  assign rdata_o = st_reg.rdata;
  assign square_output_o = st_reg.sqw_out;
  assign freq_check_o = st_reg.ft_out;
endmodule
`default_nettype wire

/* File: tb_rtcc_timer_calibration_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_rtcc_timer_calibration_control;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic pdown = 1'b0;
  logic alarm = 1'b0;
  logic watchdog_function = 1'b0;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, line_n, irq, sq, ft;
  int error_cnt = 0;
  int tests_run = 0;
  int k;

  always #4 clk = ~clk;

  // Short base tick keeps every scenario but t_out within a few thousand cycles
  rtcc_top #(.BASE_DIV(16'h0040)) i_rtcc_top (.clk_i(clk), .nrst_i(nrst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .power_down_i(pdown),
    .alarm_enable_i(alarm), .watchdog_function_i(watchdog_function), .interrupt_line_one_n_o(line_n),
    .irq_o(irq), .square_output_o(sq), .freq_check_o(ft));
  rtcc_host_mdl i_rtcc_host_mdl (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] v);
    i_rtcc_host_mdl.bus_wr(a, v);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string n);
    i_rtcc_host_mdl.bus_rd(a, d);
    chk(n, d, e);
  endtask

  // Bounded wait on line one (s=0) or irq (s=1)
  task automatic wait_sig(input bit s, input logic v, input string n);
    int i;
    for (i = 0; i < 2000 && (s ? irq : line_n) !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk(n, {7'h00, s ? irq : line_n}, {7'h00, v});
  endtask

  // Counts edges of square (s=0) or freq check (s=1) over n cycles
  task automatic edges(input bit s, input int n);
    logic p;
    k = 0;
    // Let the edge that lands the last write settle before taking the start level
    @(posedge clk);
    #1;
    p = s ? ft : sq;
    repeat (n) begin
      @(posedge clk);
      #1;
      if ((s ? ft : sq) !== p) k++;
      p = s ? ft : sq;
    end
  endtask

  task automatic t_reset();
    rchk(8'h00, rtcc_pkg::RST_TIMER_VAL, "start");
    rchk(8'h02, 8'h02, "flags");
    rchk(8'h04, 8'h01, "clk_ctrl");
    rchk(8'h07, 8'h00, "mask");
    rchk(8'hFF, 8'h00, "unmapped");
    w(8'h05, 8'h55);
    rchk(8'h05, 8'h01, "count_ro");
  endtask

  // Roll, reload, flag clear by read, then run enable cleared mid-count
  task automatic t_timer();
    w(8'h00, 8'h03);
    w(8'h01, 8'h05);
    wait_sig(0, 0, "roll_line");
    rchk(8'h05, 8'h03, "reload");
    rchk(8'h02, 8'h03, "flag_set");
    chk("line_rel", {7'h00, line_n}, 8'h01);
    rchk(8'h02, 8'h02, "flag_clr");
    repeat (64) @(posedge clk);
    rchk(8'h05, 8'h02, "dec");
    w(8'h01, 8'h04);
    repeat (300) @(posedge clk);
    rchk(8'h05, 8'h02, "hold");
    chk("hold_line", {7'h00, line_n}, 8'h01);
  endtask

  // 64 Hz tick must not decrement like the base tick would
  task automatic t_tsel();
    w(8'h00, 8'hC8);
    w(8'h01, 8'h09);
    repeat (600) @(posedge clk);
    i_rtcc_host_mdl.bus_rd(8'h05, d);
    chk("tsel", {7'h00, d >= 8'hC7}, 8'h01);
  endtask

  // Pulse style releases the line by itself while the flag stays set
  task automatic t_style();
    w(8'h00, 8'h02);
    w(8'h01, 8'h07);
    wait_sig(0, 0, "pulse_low");
    wait_sig(0, 1, "pulse_end");
    rchk(8'h02, 8'h03, "flag_kept");
  endtask

  // Sticky status, mask, write-one clear
  task automatic t_irq();
    w(8'h07, 8'h01);
    wait_sig(1, 1, "irq_set");
    w(8'h01, 8'h00);
    w(8'h06, 8'h01);
    rchk(8'h06, 8'h00, "stat_clr");
    chk("irq_clr", {7'h00, irq}, 8'h00);
    w(8'h07, 8'h00);
    w(8'h01, 8'h01);
    repeat (300) @(posedge clk);
    chk("irq_masked", {7'h00, irq}, 8'h00);
    chk("no_irq_en", {7'h00, line_n}, 8'h01);
    rchk(8'h06, 8'h01, "stat_masked");
    w(8'h01, 8'h00);
    w(8'h06, 8'h01);
    i_rtcc_host_mdl.bus_rd(8'h02, d);
  endtask

  task automatic t_cal_halt();
    w(8'h03, 8'h3F);
    rchk(8'h03, 8'h3F, "cal_neg");
    w(8'h03, 8'h1F);
    rchk(8'h03, 8'h1F, "cal_pos");
    rchk(8'h08, 8'h00, "frozen");
    w(8'h04, 8'h00);
    rchk(8'h02, 8'h00, "halt_clr");
    @(posedge clk);
    pdown <= 1'b1;
    repeat (8) @(posedge clk);
    rchk(8'h02, 8'h02, "halt_set");
    rchk(8'h06, 8'h02, "pd_stat");
    pdown <= 1'b0;
  endtask

  task automatic blk();
    edges(1, 300);
    chk("ft_blk", {7'h00, k <= 1 && ft === 1'b0}, 8'h01);
  endtask

  // Test output, its blockers, then the first three of the four square rates and disable
  task automatic t_out();
    int i;
    w(8'h03, 8'h40);
    edges(1, 1100);
    chk("ft_run", {7'h00, k >= 3}, 8'h01);
    @(posedge clk);
    alarm <= 1'b1;
    blk();
    @(posedge clk);
    alarm <= 1'b0;
    watchdog_function <= 1'b1;
    blk();
    @(posedge clk);
    watchdog_function <= 1'b0;
    for (i = 0; i < 3; i++) begin
      // Park the output low for 10 cycles first so a rate change cannot bring a rise within 8 clocks of a fall
      w(8'h04, 8'h00);
      repeat (10) @(posedge clk);
      w(8'h04, 8'h02 | 8'(i << 2));
      edges(0, 4096);
      k = k - (64 >> (i == 0 ? 0 : 2 * i + 1));
      chk("sq_rate", {7'h00, k >= -1 && k <= 1}, 8'h01);
      chk("ft_sq", {7'h00, ft}, 8'h00);
    end
    w(8'h04, 8'h00);
    edges(0, 300);
    chk("sq_off", {7'h00, k == 0 && sq === 1'b0}, 8'h01);
    w(8'h03, 8'h00);
    edges(1, 600);
    chk("ft_off", {7'h00, k == 0 && ft === 1'b0}, 8'h01);
  endtask

  task automatic give_verdict();
    $display("Checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence after a 10-cycle reset
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_timer();
    t_tsel();
    t_style();
    t_irq();
    t_cal_halt();
    t_out();
    give_verdict();
  end

  // Hang guard, about two and a half times the expected run
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
endmodule
`default_nettype wire
